// File: logic/ssw_bank.sv
// Supply status and warning register bank with AXI4-Lite slave
//
// Overview of operation
// - Warning output ORs limit bits and secondary detectors
// - Secondary detectors count only in digital mode
// - Status reads show live detector states, unlatched
// - Over low: positive 1-4, high, dual 1-3
// - Over high: dual 4 and 5, rest unused
// - Under low: same layout as over low
// - Under high: dual 4 and 5, rest unused
// - Limit low: positive, high, dual 1-3 results
// - Limit high: dual 4 and 5 results
// - Level register: conditioned dual 1-5 levels
`timescale 1ns/1ps
`default_nettype none
`include "ssw_cfg.svh"

module ssw_bank #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Primary supply fault detectors: positive 1..4 in bits 0..3, high voltage in bit 4
  input wire ssw_pkg::ssw_chan_type primary_over,
  input wire ssw_pkg::ssw_chan_type primary_under,
  // Detectors on dual inputs 1..5 used as analog supplies
  input wire ssw_pkg::ssw_chan_type dual_over,
  input wire ssw_pkg::ssw_chan_type dual_under,
  // Secondary detectors on positive 1..4 and high voltage input
  input wire ssw_pkg::ssw_chan_type secondary_over,
  input wire ssw_pkg::ssw_chan_type secondary_under,
  // ADC limit results, polarity already applied by the comparators
  input wire ssw_pkg::ssw_limit_type limit_flags,
  // Conditioned general logic input levels of dual inputs 1..5
  input wire ssw_pkg::ssw_chan_type logic_level,
  // Combined warning towards the state machine core
  output logic combined_warning,
  // Level interrupt
  output logic irq
);

  import ssw_pkg::*;

  localparam int IDX_W = ADDR_W - 2;

  if (ADDR_W < 10) begin : g_addr_check
    $error("ssw_bank: ADDR_W must be at least 10");
  end

  //--------------------------------------------------------------------
  // Input synchronisation
  //--------------------------------------------------------------------

  ssw_chan_type pri_over_s;
  ssw_chan_type pri_under_s;
  ssw_chan_type dual_over_s;
  ssw_chan_type dual_under_s;
  ssw_chan_type sec_over_s;
  ssw_chan_type sec_under_s;
  ssw_limit_type limit_s;
  ssw_chan_type level_s;

  // All detector levels pass two flops before use
  ssw_sync #(.WIDTH(7 * `SSW_CHAN_CNT + `SSW_LIMIT_CNT)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({primary_over, primary_under, dual_over, dual_under,
               secondary_over, secondary_under, limit_flags, logic_level}),
    .sync_out({pri_over_s, pri_under_s, dual_over_s, dual_under_s,
               sec_over_s, sec_under_s, limit_s, level_s})
  );

  //--------------------------------------------------------------------
  // Flag selection and warning
  //--------------------------------------------------------------------

  logic [4:0] dual_mode_reg;
  ssw_chan_type sec_over_live;
  ssw_chan_type sec_under_live;
  ssw_chan_type sel_over;
  ssw_chan_type sel_under;

  // Secondary detectors act only where the dual input is digital
  assign sec_over_live = sec_over_s & dual_mode_reg;
  assign sec_under_live = sec_under_s & dual_mode_reg;

  // Dual slot shows analog detector or the positive input warning
  assign sel_over = (dual_over_s & ~dual_mode_reg) | sec_over_live;
  assign sel_under = (dual_under_s & ~dual_mode_reg) | sec_under_live;

  // Wide OR of every limit bit and every live secondary detector
  assign combined_warning = (|limit_s) | (|sec_over_live) | (|sec_under_live);

  //--------------------------------------------------------------------
  // Status register images
  //--------------------------------------------------------------------

  ssw_byte_type over_low;
  ssw_byte_type over_high;
  ssw_byte_type under_low;
  ssw_byte_type under_high;
  ssw_byte_type limit_low;
  ssw_byte_type limit_high;
  ssw_byte_type levels;

  // Live images, no holding stage
  assign over_low = {sel_over[2:0], pri_over_s};
  assign over_high = {6'h00, sel_over[4:3]};
  assign under_low = {sel_under[2:0], pri_under_s};
  assign under_high = {6'h00, sel_under[4:3]};
  assign limit_low = limit_s[7:0];
  assign limit_high = {6'h00, limit_s[9:8]};
  assign levels = {3'h0, level_s};

  //--------------------------------------------------------------------
  // Interrupt events
  //--------------------------------------------------------------------

  logic warn_prev_reg;
  logic over_prev_reg;
  logic under_prev_reg;
  ssw_chan_type level_prev_reg;
  logic any_over;
  logic any_under;
  logic [3:0] event_pulse;
  logic [3:0] irq_clear;
  logic [3:0] irq_enable_reg;
  logic [3:0] irq_status;

  assign any_over = (|pri_over_s) | (|sel_over);
  assign any_under = (|pri_under_s) | (|sel_under);

  // Rising warning, first over or under fault after none, any level change
  assign event_pulse[`SSW_EV_WARNING] = combined_warning & ~warn_prev_reg;
  assign event_pulse[`SSW_EV_OVER] = any_over & ~over_prev_reg;
  assign event_pulse[`SSW_EV_UNDER] = any_under & ~under_prev_reg;
  assign event_pulse[`SSW_EV_LEVEL] = |(level_s ^ level_prev_reg);

  // Previous values for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warn_prev_reg <= 1'b0;
      over_prev_reg <= 1'b0;
      under_prev_reg <= 1'b0;
      level_prev_reg <= '0;
    end else begin
      warn_prev_reg <= combined_warning;
      over_prev_reg <= any_over;
      under_prev_reg <= any_under;
      level_prev_reg <= level_s;
    end
  end

  ssw_irq #(.WIDTH(`SSW_EVENT_CNT)) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_pulse(event_pulse),
    .clear_pulse(irq_clear),
    .enable(irq_enable_reg),
    .status(irq_status),
    .irq(irq)
  );

  //--------------------------------------------------------------------
  // AXI4-Lite write channel
  //--------------------------------------------------------------------

  ssw_wr_state_type wr_state_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [7:0] wr_byte_reg;
  logic wr_lane0_reg;
  logic [1:0] bresp_reg;
  logic aw_take;
  logic w_take;
  logic wr_go;
  logic wr_hit_mode;
  logic wr_hit_enable;
  logic wr_hit_clear;
  logic wr_hit_status;

  // Address and data accepted in either order while collecting
  assign s_axi_awready = (wr_state_reg == SSW_WR_COLLECT) && !aw_held_reg;
  assign s_axi_wready = (wr_state_reg == SSW_WR_COLLECT) && !w_held_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = (wr_state_reg == SSW_WR_COLLECT) && aw_held_reg && w_held_reg;

  // Write decode
  assign wr_hit_mode = wr_idx_reg == IDX_W'(`SSW_DUAL_MODE_IDX);
  assign wr_hit_enable = wr_idx_reg == IDX_W'(`SSW_IRQ_ENABLE_IDX);
  assign wr_hit_clear = wr_idx_reg == IDX_W'(`SSW_IRQ_CLEAR_IDX);
  // Status writes are answered but change nothing
  assign wr_hit_status = (wr_idx_reg >= IDX_W'(`SSW_OVER_LOW_IDX) &&
                          wr_idx_reg <= IDX_W'(`SSW_LEVELS_IDX)) ||
                         wr_idx_reg == IDX_W'(`SSW_IRQ_STATUS_IDX);

  assign irq_clear = (wr_go && wr_hit_clear && wr_lane0_reg) ? wr_byte_reg[3:0] : 4'h0;

  // Write channel state and holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= SSW_WR_COLLECT;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_idx_reg <= '0;
      wr_byte_reg <= 8'h00;
      wr_lane0_reg <= 1'b0;
      bresp_reg <= `SSW_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        wr_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wr_byte_reg <= s_axi_wdata[7:0];
        wr_lane0_reg <= s_axi_wstrb[0];
      end
      unique case (wr_state_reg)
        SSW_WR_COLLECT: begin
          if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bresp_reg <= (wr_hit_mode || wr_hit_enable || wr_hit_clear || wr_hit_status) ?
                         `SSW_RESP_OKAY : `SSW_RESP_DECERR;
            wr_state_reg <= SSW_WR_RESP;
          end
        end
        SSW_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= SSW_WR_COLLECT;
          end
        end
      endcase
    end
  end

  assign s_axi_bvalid = wr_state_reg == SSW_WR_RESP;
  assign s_axi_bresp = bresp_reg;

  // Control registers written through byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dual_mode_reg <= `SSW_DUAL_MODE_RESET;
      irq_enable_reg <= `SSW_IRQ_ENABLE_RESET;
    end else if (wr_go && wr_lane0_reg) begin
      if (wr_hit_mode) dual_mode_reg <= wr_byte_reg[4:0];
      if (wr_hit_enable) irq_enable_reg <= wr_byte_reg[3:0];
    end
  end

  //--------------------------------------------------------------------
  // AXI4-Lite read channel
  //--------------------------------------------------------------------

  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic ar_take;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_hit;

  assign s_axi_arready = !rvalid_reg;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // Read select; the clear register reads as zero
  assign rd_byte =
    (rd_idx == IDX_W'(`SSW_OVER_LOW_IDX)) ? over_low :
    (rd_idx == IDX_W'(`SSW_OVER_HIGH_IDX)) ? over_high :
    (rd_idx == IDX_W'(`SSW_UNDER_LOW_IDX)) ? under_low :
    (rd_idx == IDX_W'(`SSW_UNDER_HIGH_IDX)) ? under_high :
    (rd_idx == IDX_W'(`SSW_LIMIT_LOW_IDX)) ? limit_low :
    (rd_idx == IDX_W'(`SSW_LIMIT_HIGH_IDX)) ? limit_high :
    (rd_idx == IDX_W'(`SSW_LEVELS_IDX)) ? levels :
    (rd_idx == IDX_W'(`SSW_DUAL_MODE_IDX)) ? {3'h0, dual_mode_reg} :
    (rd_idx == IDX_W'(`SSW_IRQ_STATUS_IDX)) ? {4'h0, irq_status} :
    (rd_idx == IDX_W'(`SSW_IRQ_ENABLE_IDX)) ? {4'h0, irq_enable_reg} :
    8'h00;

  assign rd_hit = (rd_idx >= IDX_W'(`SSW_OVER_LOW_IDX) &&
                   rd_idx <= IDX_W'(`SSW_LEVELS_IDX)) ||
                  (rd_idx >= IDX_W'(`SSW_DUAL_MODE_IDX) &&
                   rd_idx <= IDX_W'(`SSW_IRQ_CLEAR_IDX));

  // Read data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `SSW_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h00_0000, rd_byte};
      rresp_reg <= rd_hit ? `SSW_RESP_OKAY : `SSW_RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : ssw_bank

`default_nettype wire

// File: logic/ssw_cfg.svh
// Register offsets, field positions, reset values and bus codes for the status bank
`ifndef SSW_CFG_SVH
`define SSW_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define SSW_OVER_LOW_IDX 8'hE2
`define SSW_OVER_HIGH_IDX 8'hE3
`define SSW_UNDER_LOW_IDX 8'hE4
`define SSW_UNDER_HIGH_IDX 8'hE5
`define SSW_LIMIT_LOW_IDX 8'hE6
`define SSW_LIMIT_HIGH_IDX 8'hE7
`define SSW_LEVELS_IDX 8'hE8
`define SSW_DUAL_MODE_IDX 8'hF0
`define SSW_IRQ_STATUS_IDX 8'hF1
`define SSW_IRQ_ENABLE_IDX 8'hF2
`define SSW_IRQ_CLEAR_IDX 8'hF3

// Channel counts
`define SSW_CHAN_CNT 5
`define SSW_LIMIT_CNT 10
`define SSW_EVENT_CNT 4

// Field positions: positive inputs and high voltage input in the low register
`define SSW_LOW_PRIMARY_LSB 0
`define SSW_LOW_DUAL_LSB 5
`define SSW_LOW_DUAL_CNT 3
`define SSW_HIGH_DUAL_FIRST 3

// Interrupt event bit positions
`define SSW_EV_WARNING 0
`define SSW_EV_OVER 1
`define SSW_EV_UNDER 2
`define SSW_EV_LEVEL 3

// Reset values
`define SSW_DUAL_MODE_RESET 5'h00
`define SSW_IRQ_ENABLE_RESET 4'h0

// AXI response codes
`define SSW_RESP_OKAY 2'h0
`define SSW_RESP_SLVERR 2'h2
`define SSW_RESP_DECERR 2'h3

`endif

// File: logic/ssw_irq.sv
// Sticky event status with enable mask and one level interrupt
`timescale 1ns/1ps
`default_nettype none

module ssw_irq #(
  parameter int WIDTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] event_pulse,
  input wire logic [WIDTH-1:0] clear_pulse,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] status,
  output logic irq
);

  logic [WIDTH-1:0] status_reg;
  logic [WIDTH-1:0] status_next;
  logic irq_reg;

  if (WIDTH < 1) begin : g_width_check
    $error("ssw_irq: WIDTH must be at least 1");
  end

  // A new event wins over a clear in the same cycle
  assign status_next = (status_reg & ~clear_pulse) | event_pulse;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & enable);
    end
  end

  assign status = status_reg;
  assign irq = irq_reg;

endmodule : ssw_irq

`default_nettype wire

// File: logic/ssw_pkg.sv
// Types shared by the supply status and warning bank
package ssw_pkg;

  // One flag per monitored channel (positive 1..4, high voltage)
  typedef logic [4:0] ssw_chan_type;
  // One ADC limit result per channel
  typedef logic [9:0] ssw_limit_type;
  // Register data byte
  typedef logic [7:0] ssw_byte_type;
  // Write channel progress
  typedef enum logic [0:0] {
    SSW_WR_COLLECT,
    SSW_WR_RESP
  } ssw_wr_state_type;

endpackage : ssw_pkg

// File: logic/ssw_sync.sv
// Two-stage synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none

module ssw_sync #(
  parameter int WIDTH = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  if (WIDTH < 1) begin : g_width_check
    $error("ssw_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : ssw_sync

`default_nettype wire

// File: verif/ssw_bank_properties.sv
// Bus handshake and warning properties of the status bank
`timescale 1ns/1ps
`default_nettype none

module ssw_bank_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ssw_pkg::ssw_limit_type limit_flags,
  input wire ssw_pkg::ssw_chan_type secondary_over,
  input wire ssw_pkg::ssw_chan_type secondary_under,
  input wire logic combined_warning,
  input wire logic irq
);
  import ssw_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("unused read bits set");

  // ----------------------------------------
  // Combined warning
  // ----------------------------------------
  a_warn_limit: assert property ((|limit_flags) [*3] |-> combined_warning)
    else $error("limit flag gives no warning");
  a_warn_quiet: assert property ((limit_flags == '0 && secondary_over == '0
    && secondary_under == '0) [*3] |-> !combined_warning)
    else $error("warning without cause");

  // Main scenarios
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_decode_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
  c_irq: cover property ($rose(irq));
  c_warn: cover property ($rose(combined_warning));
endmodule : ssw_bank_properties

bind ssw_bank ssw_bank_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .limit_flags, .secondary_over,
  .secondary_under, .combined_warning, .irq);

`default_nettype wire

// File: verif/ssw_bank_tb_top.sv
// Self-checking bench for the status bank
`timescale 1ns/1ps
`default_nettype none
`include "ssw_cfg.svh"

module ssw_bank_tb_top;
  import ssw_pkg::*;
  logic aclk, aresetn, step;
  logic [1:0] fill, resp, s_axi_bresp, s_axi_rresp;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  ssw_chan_type primary_over, primary_under, dual_over, dual_under;
  ssw_chan_type secondary_over, secondary_under, logic_level;
  ssw_limit_type limit_flags;
  logic combined_warning, irq;
  logic [7:0] mode, data;
  int err_count, checks_done;

  ssw_detect_model model (.aclk, .step, .fill, .primary_over, .primary_under, .dual_over,
    .dual_under, .secondary_over, .secondary_under, .limit_flags, .logic_level);
  ssw_bank uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primary_over, .primary_under, .dual_over,
    .dual_under, .secondary_over, .secondary_under, .limit_flags, .logic_level,
    .combined_warning, .irq);

  // Clock, 5 ns period
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [7:0] expect_byte(input logic [7:0] idx);
    ssw_chan_type ov, uv;
    ov = (mode[4:0] & secondary_over) | (~mode[4:0] & dual_over);
    uv = (mode[4:0] & secondary_under) | (~mode[4:0] & dual_under);
    case (idx)
      `SSW_OVER_LOW_IDX: return {ov[2:0], primary_over};
      `SSW_OVER_HIGH_IDX: return {6'h00, ov[4:3]};
      `SSW_UNDER_LOW_IDX: return {uv[2:0], primary_under};
      `SSW_UNDER_HIGH_IDX: return {6'h00, uv[4:3]};
      `SSW_LIMIT_LOW_IDX: return limit_flags[7:0];
      `SSW_LIMIT_HIGH_IDX: return {6'h00, limit_flags[9:8]};
      default: return {3'h0, logic_level};
    endcase
  endfunction : expect_byte

  function automatic logic expect_warning();
    return (|limit_flags) | (|(mode[4:0] & (secondary_over | secondary_under)));
  endfunction : expect_warning

  // ----------------------------------------
  // Bus tasks and checks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [7:0] d, output logic [1:0] r);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask : rd

  // New detector levels, then wait out the input synchronisers
  task automatic settle(input logic [1:0] f);
    fill <= f;
    step <= 1'b1;
    @(posedge aclk);
    step <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : settle

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  // Watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9F9B));
    {aresetn, step, fill, mode, err_count, checks_done} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = {4'hF, 2'h3};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Quiet, all asserted, then random levels; analog, digital and mixed dual modes
    for (int t = 0; t < 12; t++) begin
      mode = (t % 3 == 1) ? 8'h1F : (t % 3 == 2) ? (8'($urandom) & 8'h1F) : 8'h00;
      wr(`SSW_DUAL_MODE_IDX, mode, resp);
      rd(`SSW_DUAL_MODE_IDX, data, resp);
      chk("mode readback", 32'(data), 32'(mode));
      settle((t < 2) ? 2'(t + 1) : 2'h0);
      chk("warning", 32'(combined_warning), 32'(expect_warning()));
      for (int i = 32'hE2; i <= 32'hE8; i++) begin
        wr(8'(i), 8'hFF, resp);
        chk("status write resp", 32'(resp), 32'(`SSW_RESP_OKAY));
        rd(8'(i), data, resp);
        chk("status byte", 32'(data), 32'(expect_byte(8'(i))));
      end
    end
    // Unmapped place
    rd(8'hFF, data, resp);
    chk("unmapped read resp", 32'(resp), 32'(`SSW_RESP_DECERR));
    chk("unmapped read data", 32'(data), 32'h0);
    wr(8'hFF, 8'h5A, resp);
    chk("unmapped write resp", 32'(resp), 32'(`SSW_RESP_DECERR));
    // Lane 0 off: control write answered but ignored; clear register reads zero
    s_axi_wstrb <= 4'hE;
    wr(`SSW_DUAL_MODE_IDX, ~mode, resp);
    s_axi_wstrb <= 4'hF;
    chk("masked write resp", 32'(resp), 32'(`SSW_RESP_OKAY));
    rd(`SSW_DUAL_MODE_IDX, data, resp);
    chk("masked mode write", 32'(data), 32'(mode));
    rd(`SSW_IRQ_CLEAR_IDX, data, resp);
    chk("clear reads zero", 32'(data), 32'h0);
    // Interrupt: raise, mask, unmask, clear
    settle(2'h1);
    wr(`SSW_IRQ_CLEAR_IDX, 8'h0F, resp);
    wr(`SSW_IRQ_ENABLE_IDX, 8'h08, resp);
    repeat (3) @(posedge aclk);
    chk("irq idle", 32'(irq), 32'h0);
    settle(2'h2);
    chk("irq raised", 32'(irq), 32'h1);
    rd(`SSW_IRQ_STATUS_IDX, data, resp);
    chk("event status", 32'(data), 32'h0F);
    wr(`SSW_IRQ_ENABLE_IDX, 8'h00, resp);
    repeat (2) @(posedge aclk);
    chk("irq masked", 32'(irq), 32'h0);
    wr(`SSW_IRQ_ENABLE_IDX, 8'h08, resp);
    repeat (2) @(posedge aclk);
    chk("irq sticky", 32'(irq), 32'h1);
    wr(`SSW_IRQ_CLEAR_IDX, 8'h08, resp);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'(irq), 32'h0);
    rd(`SSW_IRQ_STATUS_IDX, data, resp);
    chk("status after clear", 32'(data), 32'h07);
    summarize();
  end
endmodule : ssw_bank_tb_top

`default_nettype wire

// File: verif/ssw_detect_model.sv
// Model of the detectors, limit comparators and input conditioning
`timescale 1ns/1ps
`default_nettype none

module ssw_detect_model (
  input wire logic aclk,
  input wire logic step,
  input wire logic [1:0] fill,
  output ssw_pkg::ssw_chan_type primary_over,
  output ssw_pkg::ssw_chan_type primary_under,
  output ssw_pkg::ssw_chan_type dual_over,
  output ssw_pkg::ssw_chan_type dual_under,
  output ssw_pkg::ssw_chan_type secondary_over,
  output ssw_pkg::ssw_chan_type secondary_under,
  output ssw_pkg::ssw_limit_type limit_flags,
  output ssw_pkg::ssw_chan_type logic_level
);
  import ssw_pkg::*;

  // Pattern: 1 all quiet, 2 all asserted, else random
  function automatic logic [31:0] pick();
    return (fill == 2'h1) ? 32'h0 : (fill == 2'h2) ? 32'hFFFFFFFF : $urandom;
  endfunction : pick

  // Levels start quiet
  initial begin
    {primary_over, primary_under, dual_over, dual_under} = '0;
    {secondary_over, secondary_under, limit_flags, logic_level} = '0;
  end

  // New levels on each step, held in between
  always @(posedge aclk) begin
    if (step) begin
      primary_over <= ssw_chan_type'(pick());
      primary_under <= ssw_chan_type'(pick());
      dual_over <= ssw_chan_type'(pick());
      dual_under <= ssw_chan_type'(pick());
      secondary_over <= ssw_chan_type'(pick());
      secondary_under <= ssw_chan_type'(pick());
      limit_flags <= ssw_limit_type'(pick());
      logic_level <= ssw_chan_type'(pick());
    end
  end
endmodule : ssw_detect_model

`default_nettype wire
